// *** core/fcs_pkg.sv ***
// Shared constants and carriers for the frame check field generator.
// Assumes a single clock domain; no software-visible registers.
package fcs_pkg;

    localparam int          CRC_W       = 32;
    localparam int          BYTE_W      = 8;
    localparam logic [31:0] GEN_POLY    = 32'h04c11db7;
    localparam logic [31:0] PRESET_VAL  = 32'hffffffff;
    localparam logic [31:0] RESIDUE_VAL = 32'hc704dd7b;
    localparam logic [7:0]  FILL_BYTE   = 8'hff;
    localparam logic [7:0]  OUT_RESET   = 8'hff;
    localparam int          FIFO_DEPTH  = 8;
    localparam logic [2:0]  EMIT_BYTES  = 3'h4;

    // One input beat from the framing logic
    typedef struct packed {
        logic       presetReq;
        logic       calcPhase;
        logic       bitMode;
        logic [7:0] data;
    } beat_t;

    // Checker results
    typedef struct packed {
        logic [7:0]  outByte;
        logic [31:0] state;
        logic        outValid;
        logic        residueOk;
    } result_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CALC,
        ST_EMIT
    } phase_t;

endpackage

// *** core/beat_fifo.sv ***
// Small synchronous FIFO carrying input beats to the checker.
// Assumes one clock; parameters shape width and depth.
`timescale 1ns/1ps
module beat_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_sys,  // System clock
    input  wire logic             arst_n,   // Async reset, active low
    input  wire logic [WIDTH-1:0] inData,   // Write data
    input  wire logic             inValid,  // Write request
    output logic                  inReady,  // Not full
    output logic      [WIDTH-1:0] outData,  // Head word
    output logic                  outValid, // Not empty
    input  wire logic             outReady  // Consumer takes head
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0]   count;
    } fifo_state_t;

    fifo_state_t     st_reg;
    fifo_state_t     st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic            doWr;
    logic            doRd;

    assign inReady  = (st_reg.count != (AW+1)'(DEPTH));
    assign outValid = (st_reg.count != '0);
    assign outData  = mem[st_reg.rdPtr];
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;

    always_comb begin
        st_next = st_reg;
        if (doWr) begin
            st_next.wrPtr = st_reg.wrPtr + 1'b1;
        end
        if (doRd) begin
            st_next.rdPtr = st_reg.rdPtr + 1'b1;
        end
        if (doWr && !doRd) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (doRd && !doWr) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem[st_reg.wrPtr] <= inData;
        end
    end

endmodule

// *** core/fcs_crc32_gen.sv ***
// Frame check field generator and checker, CRC-32, byte or bit input.
// Assumes framing logic feeds beats synchronous to clk_sys.
//
// Beats pass an eight-deep buffer before they reach the remainder.
// A beat is preset, compute or shift, chosen by its control fields.
// Compute beats fold one byte, or one bit in serial mode, into the
// remainder; shift beats move the remainder up a byte for emission.
// Every processed beat refreshes the output byte and raises its valid.
// While that byte waits for the consumer no further beat is taken,
// so no output byte is ever lost; the buffer absorbs the backlog.
//
// Transmit: preset, compute beats, then four shift beats. The last
// compute beat and the first three shift beats give the field bytes;
// the fourth shift beat only flushes the remainder.
// Receive: preset, then frame and field as compute beats; residueOk
// then tells whether the frame arrived intact.
//
// Timing: a beat written into an empty buffer is processed on the
// next edge, so its output byte appears one edge after the write.
// Back-to-back beats run at one per clock while the consumer keeps
// up. The state port shows the raw remainder, never the inverted
// field, and the byte path treats data bit 0 as the first bit on
// the line.
//
// Limits: bit mode has no fast path for the field; shift beats always
// move a whole byte, so the field leaves as four bytes in either mode.
// A preset in mid-frame discards the partial remainder without a mark;
// the framing logic must know where frames begin.
//
// Reset: the remainder starts preset and the output byte starts at
// all ones with its valid low, so a bench may skip the first preset.
// The buffer is emptied as well; beats in flight at reset are lost.
`timescale 1ns/1ps
module fcs_crc32_gen
    import fcs_pkg::*;
#(
    parameter int DEPTH = fcs_pkg::FIFO_DEPTH
) (
    input  wire logic            clk_sys,  // System clock, 100 MHz
    input  wire logic            arst_n,   // Async reset, active low
    input  wire fcs_pkg::beat_t  beatIn,   // Preset, phase, mode, data
    input  wire logic            beatValid,// Input qualifier
    output logic                 beatReady,// Buffer has room
    output fcs_pkg::result_t     result,   // Output byte, state, flags
    input  wire logic            resReady  // Consumer can take a byte
);
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // Input buffer
    // ------------------------------------------------------------
    // Decouples the framing logic from output stalls; the head is
    // taken only when the output byte register is free.
    localparam int BW = $bits(beat_t);

    logic [BW-1:0] headBits;
    beat_t         head;
    logic          headValid;
    logic          take;

    beat_fifo #(
        .WIDTH (BW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .inData   (beatIn),
        .inValid  (beatValid),
        .inReady  (beatReady),
        .outData  (headBits),
        .outValid (headValid),
        .outReady (take)
    );

    assign head = beat_t'(headBits);

    // ------------------------------------------------------------
    // Next remainder
    // ------------------------------------------------------------
    // One serial step: shift left, feed back taps when bit out differs
    function automatic logic [31:0] step1(input logic [31:0] s,
                                          input logic        d);
        logic fb;
        fb = s[31] ^ d;
        step1 = {s[30:0], 1'b0} ^ (fb ? GEN_POLY : '0);
    endfunction

    // Eight serial steps, data bit 0 first
    function automatic logic [31:0] step8(input logic [31:0] s,
                                          input logic [7:0]  d);
        logic [31:0] t;
        t = s;
        for (int i = 0; i < BYTE_W; i++) begin
            t = step1(t, d[i]);
        end
        step8 = t;
    endfunction

    // Bit-reverse and complement one byte
    function automatic logic [7:0] revInv(input logic [7:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < BYTE_W; i++) begin
            r[i] = ~b[BYTE_W-1-i];
        end
        revInv = r;
    endfunction

    // ------------------------------------------------------------
    // Parallel equations
    // ------------------------------------------------------------
    // The update is linear in state and data, so each next-state bit
    // is the parity of a fixed subset of those inputs. The subsets are
    // found at elaboration by pushing single ones through the serial
    // step, which keeps the byte path equal to eight serial steps.
    // Bits 31..0 of a mask select state bits, bits 39..32 data bits;
    // the serial masks only ever select data bit 0.
    localparam int EQ_W = CRC_W + BYTE_W;

    function automatic logic [EQ_W-1:0] eqMask(input int   j,
                                               input logic ser);
        logic [EQ_W-1:0] m;
        logic [31:0]     s;
        logic [7:0]      d;
        logic [31:0]     t;
        m = '0;
        for (int k = 0; k < EQ_W; k++) begin
            s = '0;
            d = '0;
            if (k < CRC_W) begin
                s[k] = 1'b1;
            end else begin
                d[k-CRC_W] = 1'b1;
            end
            if (ser) begin
                t = step1(s, d[0]);
            end else begin
                t = step8(s, d);
            end
            m[k] = t[j];
        end
        eqMask = m;
    endfunction

    logic [EQ_W-1:0] eqIn;
    logic [31:0]     byteCrc;
    logic [31:0]     bitCrc;

    // Data above state, matching the bit numbering of the masks
    assign eqIn = {head.data, st_reg.crc};

    for (genvar j = 0; j < CRC_W; j++) begin : g_eq
        localparam logic [EQ_W-1:0] BYTE_M = eqMask(j, 1'b0);
        localparam logic [EQ_W-1:0] BIT_M  = eqMask(j, 1'b1);
        assign byteCrc[j] = ^(eqIn & BYTE_M);
        assign bitCrc[j]  = ^(eqIn & BIT_M);
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Remainder, output byte and its valid, plus phase bookkeeping
    // that tracks how far the field emission has gone.
    typedef struct packed {
        logic [31:0] crc;
        logic [7:0]  outByte;
        logic        outValid;
        phase_t      phase;
        logic [2:0]  emitCnt;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    logic [31:0] nextCrc;
    logic        outBusy;

    // Stall while an emitted byte is waiting for the consumer
    assign outBusy = st_reg.outValid && !resReady;
    assign take    = headValid && !outBusy;

    // ------------------------------------------------------------
    // Beat decode
    // ------------------------------------------------------------
    // A beat only acts on the edge it is taken; preset outranks the
    // compute and shift choices for the remainder, while the output
    // byte still follows the compute control. Both candidate bytes
    // are formed every cycle so the choice is a plain select.
    logic       doPreset;
    logic       doCalc;
    logic       doShift;
    logic [7:0] calcByte;
    logic [7:0] shiftByte;

    assign doPreset  = take && head.presetReq;
    assign doCalc    = take && head.calcPhase;
    assign doShift   = take && !head.calcPhase;
    assign calcByte  = revInv(nextCrc[31:24]);
    assign shiftByte = revInv(st_reg.crc[23:16]);

    always_comb begin
        if (head.bitMode) begin
            nextCrc = bitCrc;
        end else begin
            nextCrc = byteCrc;
        end
    end

    // Next state. The consumer's take and a new beat may meet in one
    // cycle; the new beat's valid wins, so no byte is dropped.
    // The remainder moves only on a taken beat; an idle cycle keeps
    // every field but the output valid, which the consumer's take clears.
    always_comb begin
        st_next = st_reg;
        if (st_reg.outValid && resReady) begin
            st_next.outValid = 1'b0;
        end
        if (take) begin
            if (doCalc) begin
                st_next.outByte  = calcByte;
                st_next.outValid = 1'b1;
                st_next.phase    = ST_CALC;
                st_next.emitCnt  = '0;
            end else begin
                st_next.outByte  = shiftByte;
                st_next.outValid = 1'b1;
                st_next.phase    = ST_EMIT;
                if (st_reg.emitCnt != EMIT_BYTES) begin
                    st_next.emitCnt = st_reg.emitCnt + 1'b1;
                end
            end
            if (doPreset) begin
                st_next.crc   = PRESET_VAL;
                st_next.phase = ST_IDLE;
                st_next.emitCnt = '0;
            end else if (doCalc) begin
                st_next.crc = nextCrc;
            end else if (doShift) begin
                st_next.crc = {st_reg.crc[23:0], FILL_BYTE};
            end
        end
        // Phase follows the beat just taken; an unknown code falls
        // back to idle and clears the emission count.
        case (st_next.phase)
            ST_IDLE: begin
                st_next.phase = ST_IDLE;
            end
            ST_CALC: begin
                st_next.phase = ST_CALC;
            end
            ST_EMIT: begin
                st_next.phase = ST_EMIT;
            end
            default: begin
                st_next.phase   = ST_IDLE;
                st_next.emitCnt = '0;
            end
        endcase
    end

    // Field by field reset so the remainder comes up preset and the
    // output byte comes up at all ones, not at zero.
    // Everything else moves on the rising edge only.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg.crc      <= PRESET_VAL;
            st_reg.outByte  <= OUT_RESET;
            st_reg.outValid <= 1'b0;
            st_reg.phase    <= ST_IDLE;
            st_reg.emitCnt  <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All straight from the state register; only the residue flag
    // adds a compare, so it settles one gate level behind the rest.
    // The compare is meaningful only after a full frame and field.
    assign result.outByte   = st_reg.outByte;
    assign result.state     = st_reg.crc;
    assign result.outValid  = st_reg.outValid;
    assign result.residueOk = (st_reg.crc == RESIDUE_VAL);

endmodule

// *** tb/fcs_gen_properties.sv ***
// Port checks for the frame check field generator.
// Assumes it is bound onto fcs_crc32_gen.
`timescale 1ns/1ps
module fcs_gen_check
    import fcs_pkg::*;
(
    input wire logic             clk_sys,   // Clock
    input wire logic             arst_n,    // Reset, low
    input wire fcs_pkg::beat_t   beatIn,    // Beat
    input wire logic             beatValid, // Qualifier
    input wire logic             beatReady, // Room
    input wire fcs_pkg::result_t result,    // Results
    input wire logic             resReady   // Taken
);
    // ----
    // Checks
    // ----
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_reset_state: assert property (
        $rose(arst_n) |-> result.state == PRESET_VAL && !result.outValid)
        else $error("state not preset");
    a_residue_flag: assert property (
        result.residueOk == (result.state == RESIDUE_VAL))
        else $error("residue flag wrong");
    a_state_cause: assert property (
        $changed(result.state) |-> result.outValid)
        else $error("state moved alone");
    a_byte_cause: assert property (
        $changed(result.outByte) |-> result.outValid)
        else $error("byte moved alone");
    a_stall_hold: assert property (
        result.outValid && !resReady |=> result.outValid
        && $stable(result.state) && $stable(result.outByte))
        else $error("stall not held");
    a_full_cause: assert property (
        $fell(beatReady) |-> $past(beatValid))
        else $error("full without write");
    a_slot_free: assert property (
        $rose(beatReady) |-> result.outValid)
        else $error("slot freed alone");
    a_beat_answer: assert property (
        beatValid && beatReady |-> ##[1:100] result.outValid)
        else $error("beat never answered");
    c_stall: cover property (result.outValid && !resReady ##1 !beatReady);
    c_residue: cover property ($rose(result.residueOk));
    c_emit: cover property ((beatValid && !beatIn.calcPhase) [*4]);
endmodule
bind fcs_crc32_gen fcs_gen_check chk (.clk_sys(clk_sys), .arst_n(arst_n),
    .beatIn(beatIn), .beatValid(beatValid), .beatReady(beatReady),
    .result(result), .resReady(resReady));

// *** tb/mac_feeder.sv ***
// Framing logic model handing beats to the generator.
// Assumes send and idle are called at falling edges.
`timescale 1ns/1ps
module mac_feeder
    import fcs_pkg::*;
(
    input  wire logic      clk_sys,   // Clock
    output fcs_pkg::beat_t beatIn,    // Beat
    output logic           beatValid, // Qualifier
    input  wire logic      beatReady  // Room
);
    // ----
    // Beat source
    // ----
    initial begin
        beatIn = '0;
        beatValid = 1'b0;
    end
    task automatic send(input beat_t b, input int gap);
        beatIn <= b;
        beatValid <= 1'b1;
        do @(posedge clk_sys); while (beatReady !== 1'b1);
        @(negedge clk_sys);
        if (gap > 0) idle();
        repeat (gap) @(negedge clk_sys);
    endtask
    task automatic idle();
        beatValid <= 1'b0;
        beatIn <= ~beatIn;
    endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the frame check field generator.
// Assumes mac_feeder as beat source.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import fcs_pkg::*;
    logic        clk_sys;
    logic        arst_n;
    beat_t       beatIn;
    logic        beatValid;
    logic        beatReady;
    result_t     result;
    logic        resReady;
    logic        hold;
    logic [31:0] rnd;
    logic [31:0] crc;
    logic [7:0]  ob;
    int          n_fail;
    int          checks_done;
    beat_t       expQ[$];
    logic [7:0]  field[$];
    logic [7:0]  msg[$];
    fcs_crc32_gen uut (.clk_sys(clk_sys), .arst_n(arst_n), .beatIn(beatIn),
        .beatValid(beatValid), .beatReady(beatReady), .result(result),
        .resReady(resReady));
    mac_feeder mac (.clk_sys(clk_sys), .beatIn(beatIn),
        .beatValid(beatValid), .beatReady(beatReady));
    // ----
    // Reference
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000c5 : 32'h0);
    endfunction
    function automatic logic [7:0] flip(input logic [7:0] x);
        for (int i = 0; i < 8; i++) flip[i] = ~x[7 - i];
    endfunction
    function automatic logic [7:0] step(input beat_t b);
        logic [31:0] n;
        logic        fb;
        n = crc;
        for (int i = 0; i < (b.bitMode ? 1 : BYTE_W); i++) begin
            fb = n[31] ^ b.data[i];
            n = {n[30:0], 1'b0} ^ ({CRC_W{fb}} & GEN_POLY);
        end
        step = b.calcPhase ? flip(n[31:24]) : flip(crc[23:16]);
        if (!b.calcPhase) n = {crc[23:0], FILL_BYTE};
        if (!b.presetReq) field.push_back(step);
        crc = b.presetReq ? PRESET_VAL : n;
    endfunction
    always @(posedge clk_sys) begin
        if (arst_n && result.outValid === 1'b1 && resReady && expQ.size()) begin
            ob = step(expQ.pop_front());
            `CHK("outByte", ob, result.outByte)
            `CHK("state", crc, result.state)
        end
        if (arst_n && beatValid && beatReady === 1'b1) expQ.push_back(beatIn);
    end
    always @(negedge clk_sys) begin
        rnd <= lfsr(rnd);
        resReady <= !hold && rnd[3:2] != 2'b00;
    end
    // ----
    // Stimulus
    // ----
    task automatic put(input logic [7:0] d, input logic ser);
        if (ser)
            for (int i = 0; i < 8; i++)
                mac.send({2'b01, 1'b1, rnd[7:1], d[i]}, rnd[1:0] == 2'b00);
        else
            mac.send({2'b01, 1'b0, d}, rnd[1:0] == 2'b00);
    endtask
    task automatic drain();
        mac.idle();
        for (int i = 0; i < 400 && expQ.size() > 0; i++) @(negedge clk_sys);
        `CHK("drained", 0, expQ.size())
    endtask
    task automatic frame(input int n, input logic ser, input logic bad);
        int base;
        msg.delete();
        field.delete();
        mac.send({1'b1, rnd[0], ser, rnd[15:8]}, 0);
        for (int i = 0; i < n; i++) begin
            msg.push_back(rnd[15:8]);
            put(msg[i], ser);
        end
        for (int i = 0; i < 4; i++) mac.send({2'b00, ser, rnd[7:0]}, 0);
        drain();
        base = field.size() - 5;
        mac.send({2'b11, ser, 8'h00}, 0);
        msg[0] ^= {7'h0, bad};
        foreach (msg[i]) put(msg[i], ser);
        for (int i = 0; i < 4; i++) put(field[base + i], ser);
        drain();
        `CHK("residueOk", !bad, result.residueOk)
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        arst_n = 1'b0;
        hold = 1'b0;
        resReady = 1'b0;
        rnd = 32'h86cf1615;
        crc = PRESET_VAL;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(negedge clk_sys);
        arst_n = 1'b1;
        `CHK("resetState", PRESET_VAL, result.state)
        frame(20, 1'b0, 1'b0);
        frame(9, 1'b0, 1'b1);
        frame(6, 1'b1, 1'b0);
        hold <= 1'b1;
        fork
            frame(12, 1'b0, 1'b0);
        join_none
        repeat (30) @(negedge clk_sys);
        `CHK("fullRefused", 1'b0, beatReady)
        hold <= 1'b0;
        wait fork;
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end
endmodule
